// ==== hdl/psefe_defs.vh ====
`ifndef PSEFE_DEFS_VH
`define PSEFE_DEFS_VH
// Command codes of the two supply register views and of the three power registers
`define PSEFE_CMD_SUPPLY_VIEW 8'h0A
`define PSEFE_CMD_SUPPLY_CLEAR 8'h0B
`define PSEFE_CMD_PWR_ON_FAULT 8'h24
`define PSEFE_CMD_PWR_ON 8'h19
`define PSEFE_CMD_PWR_ALLOC 8'h29
// Supply and fault event bit positions
`define PSEFE_BIT_THERMAL 7
`define PSEFE_BIT_VDD_LOCKOUT 6
`define PSEFE_BIT_VDD_WARN 5
`define PSEFE_BIT_MAIN_UV 4
`define PSEFE_BIT_CUT_B 3
`define PSEFE_BIT_CUT_A 2
`define PSEFE_BIT_FAST_SHUT 1
`define PSEFE_BIT_MEM_FAULT 0
// Reset value: both logic supply flags set after power-on
`define PSEFE_SUPPLY_RESET 8'h60
// Cool-down time and cycle count at 200 MHz
`define PSEFE_COOL_MS 1000
`define PSEFE_CLK_KHZ 200000
`define PSEFE_COOL_CYCLES (`PSEFE_COOL_MS * `PSEFE_CLK_KHZ)
// Class threshold: at or below this, single-channel inrush
`define PSEFE_CLASS_SEQ_MAX 4'h6
`endif

// ==== hdl/psefe_port_seq.v ====
`include "psefe_defs.vh"
// Turn-on sequencer for one 4-pair port (channels a and b)
module psefe_port_seq #(
  parameter COOL_CYCLES = `PSEFE_COOL_CYCLES
) (
  input wire clock_i,
  input wire rst_i,
  input wire start_i,
  input wire dual_sig_i,
  input wire [3:0] class_i,
  input wire inrush_done_a_i,
  input wire inrush_done_b_i,
  input wire start_fail_a_i,
  input wire start_fail_b_i,
  input wire ilim_a_i,
  input wire ilim_b_i,
  input wire kill_i,
  input wire repower_a_i,
  input wire repower_b_i,
  output reg en_a_o,
  output reg en_b_o,
  output reg pg_a_o,
  output reg pg_b_o,
  output wire start_fault_a_o,
  output wire start_fault_b_o,
  output wire ilim_a_o,
  output wire ilim_b_o,
  output wire cooling_o
);
  localparam S_IDLE = 3'h0;
  localparam S_SEQ = 3'h1;
  localparam S_PAR = 3'h2;
  localparam S_DUAL = 3'h3;
  localparam S_ON = 3'h4;
  localparam S_COOL = 3'h5;
  reg [2:0] state_q;
  reg [31:0] cool_q;
  reg sf_a;
  reg sf_b;
  wire ss_fail;
  assign ss_fail = (state_q == S_SEQ && inrush_done_a_i && start_fail_a_i) ||
                   (state_q == S_PAR && inrush_done_a_i && inrush_done_b_i && (start_fail_a_i || start_fail_b_i));
  always @*
  begin
    sf_a = 1'b0;
    sf_b = 1'b0;
    if (ss_fail)
    begin
      sf_a = 1'b1;
      sf_b = 1'b1;
    end
    else if (state_q == S_DUAL)
    begin
      sf_a = en_a_o && inrush_done_a_i && start_fail_a_i;
      sf_b = en_b_o && inrush_done_b_i && start_fail_b_i;
    end
  end
  assign start_fault_a_o = sf_a;
  assign start_fault_b_o = sf_b;
  // Each channel reports its own current limit
  assign ilim_a_o = ilim_a_i && en_a_o;
  assign ilim_b_o = ilim_b_i && en_b_o;
  assign cooling_o = (state_q == S_COOL);
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= S_IDLE;
      cool_q <= 32'h0;
      en_a_o <= 1'b0;
      en_b_o <= 1'b0;
      pg_a_o <= 1'b0;
      pg_b_o <= 1'b0;
    end
    else if (kill_i)
    begin
      // Thermal shutdown wins over every sequence step
      state_q <= S_IDLE;
      en_a_o <= 1'b0;
      en_b_o <= 1'b0;
      pg_a_o <= 1'b0;
      pg_b_o <= 1'b0;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          if (start_i && dual_sig_i)
          begin
            state_q <= S_DUAL;
            en_a_o <= 1'b1;
            en_b_o <= 1'b1;
          end
          else if (start_i && class_i <= `PSEFE_CLASS_SEQ_MAX)
          begin
            state_q <= S_SEQ;
            en_a_o <= 1'b1;
          end
          else if (start_i)
          begin
            state_q <= S_PAR;
            en_a_o <= 1'b1;
            en_b_o <= 1'b1;
          end
        end
        S_SEQ:
        begin
          if (inrush_done_a_i && !start_fail_a_i)
          begin
            state_q <= S_ON;
            en_b_o <= 1'b1;
            pg_a_o <= 1'b1;
            pg_b_o <= 1'b1;
          end
          else if (ss_fail)
          begin
            state_q <= S_COOL;
            en_a_o <= 1'b0;
            cool_q <= COOL_CYCLES - 1;
          end
        end
        S_PAR:
        begin
          if (ss_fail)
          begin
            state_q <= S_COOL;
            en_a_o <= 1'b0;
            en_b_o <= 1'b0;
            cool_q <= COOL_CYCLES - 1;
          end
          else if (inrush_done_a_i && inrush_done_b_i)
          begin
            state_q <= S_ON;
            pg_a_o <= 1'b1;
            pg_b_o <= 1'b1;
          end
        end
        S_DUAL:
        begin
          // A fault on one side never touches the other
          if (sf_a)
            en_a_o <= 1'b0;
          else if (en_a_o && inrush_done_a_i)
            pg_a_o <= 1'b1;
          else if (!en_a_o && repower_a_i)
            en_a_o <= 1'b1;
          if (sf_b)
            en_b_o <= 1'b0;
          else if (en_b_o && inrush_done_b_i)
            pg_b_o <= 1'b1;
          else if (!en_b_o && repower_b_i)
            en_b_o <= 1'b1;
          if (en_a_o && ilim_a_i)
          begin
            en_a_o <= 1'b0;
            pg_a_o <= 1'b0;
          end
          if (en_b_o && ilim_b_i)
          begin
            en_b_o <= 1'b0;
            pg_b_o <= 1'b0;
          end
        end
        S_ON:
        begin
          if (ilim_a_i || ilim_b_i)
          begin
            state_q <= S_IDLE;
            en_a_o <= 1'b0;
            en_b_o <= 1'b0;
            pg_a_o <= 1'b0;
            pg_b_o <= 1'b0;
          end
        end
        S_COOL:
        begin
          if (cool_q == 32'h0)
            state_q <= S_IDLE;
          else
            cool_q <= cool_q - 32'h1;
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end
endmodule // psefe_port_seq

// ==== hdl/psefe_supply_events.v ====
`include "psefe_defs.vh"
module psefe_supply_events #(
  parameter PORTS = 4,
  parameter COOL_CYCLES = `PSEFE_COOL_CYCLES
) (
  input wire clock_i,
  input wire rst_i,
  input wire rd_i,
  input wire [7:0] rd_cmd_i,
  output reg [7:0] rd_data_o,
  output reg rd_valid_o,
  input wire thermal_hot_i,
  input wire vdd_lockout_i,
  input wire vdd_warn_i,
  input wire main_uv_i,
  input wire cut_pair_a_i,
  input wire cut_pair_b_i,
  input wire fast_shutdown_input_i,
  input wire mem_fault_i,
  input wire [PORTS-1:0] start_i,
  input wire [PORTS-1:0] dual_sig_i,
  input wire [4*PORTS-1:0] class_i,
  input wire [PORTS-1:0] inrush_done_a_i,
  input wire [PORTS-1:0] inrush_done_b_i,
  input wire [PORTS-1:0] start_fail_a_i,
  input wire [PORTS-1:0] start_fail_b_i,
  input wire [PORTS-1:0] ilim_a_i,
  input wire [PORTS-1:0] ilim_b_i,
  input wire [2*PORTS-1:0] power_enable_change_flag_i,
  input wire [2*PORTS-1:0] power_on_command_bit_i,
  input wire [2*PORTS-1:0] fault_cause_i,
  output wire [2*PORTS-1:0] channel_en_o,
  output wire [2*PORTS-1:0] power_good_flag_o,
  output wire [2*PORTS-1:0] start_fault_flag_o,
  output wire [2*PORTS-1:0] current_limit_fault_flag_o,
  output reg [2*PORTS-1:0] inrush_fault_o,
  output reg [2*PORTS-1:0] power_on_fault_cause_o,
  output wire [PORTS-1:0] cooling_o,
  output wire supply_event_o
);
  // Two-flop synchronisers for the raw pins
  reg [7:0] sync1_q;
  reg [7:0] sync2_q;
  reg [7:0] prev_q;
  reg [7:0] events_q;
  reg [7:0] events_d;
  reg [2*PORTS-1:0] sf_seen_q;
  reg [2*PORTS-1:0] ilim_seen_q;
  reg [2*PORTS-1:0] en_prev_q;
  wire [7:0] raw;
  wire [7:0] rise;
  wire clear_rd;
  wire [2*PORTS-1:0] sf_pulse;
  wire [2*PORTS-1:0] ilim_pulse;
  wire [2*PORTS-1:0] turn_on;
  assign raw = {thermal_hot_i, vdd_lockout_i, vdd_warn_i, main_uv_i,
                cut_pair_b_i, cut_pair_a_i, fast_shutdown_input_i, mem_fault_i};
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      prev_q <= 8'h00;
    end
    else
    begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  assign rise = sync2_q & ~prev_q;
  // Thermal shutdown holds off channels only while hot, never by the flag
  wire hot;
  assign hot = sync2_q[`PSEFE_BIT_THERMAL];
  genvar g;
  generate
    for (g = 0; g < PORTS; g = g + 1)
    begin : port_g
      psefe_port_seq #(
        .COOL_CYCLES(COOL_CYCLES)
      ) u_seq (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .start_i(start_i[g]),
        .dual_sig_i(dual_sig_i[g]),
        .class_i(class_i[4*g+3:4*g]),
        .inrush_done_a_i(inrush_done_a_i[g]),
        .inrush_done_b_i(inrush_done_b_i[g]),
        .start_fail_a_i(start_fail_a_i[g]),
        .start_fail_b_i(start_fail_b_i[g]),
        .ilim_a_i(ilim_a_i[g]),
        .ilim_b_i(ilim_b_i[g]),
        .kill_i(hot),
        .repower_a_i(power_on_command_bit_i[2*g]),
        .repower_b_i(power_on_command_bit_i[2*g+1]),
        .en_a_o(channel_en_o[2*g]),
        .en_b_o(channel_en_o[2*g+1]),
        .pg_a_o(power_good_flag_o[2*g]),
        .pg_b_o(power_good_flag_o[2*g+1]),
        .start_fault_a_o(sf_pulse[2*g]),
        .start_fault_b_o(sf_pulse[2*g+1]),
        .ilim_a_o(ilim_pulse[2*g]),
        .ilim_b_o(ilim_pulse[2*g+1]),
        .cooling_o(cooling_o[g])
      );
    end
  endgenerate
  // Per-channel start and limit flags, plus cause steering
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sf_seen_q <= {2*PORTS{1'b0}};
      ilim_seen_q <= {2*PORTS{1'b0}};
      en_prev_q <= {2*PORTS{1'b0}};
      inrush_fault_o <= {2*PORTS{1'b0}};
      power_on_fault_cause_o <= {2*PORTS{1'b0}};
    end
    else
    begin
      en_prev_q <= channel_en_o;
      // Flags outlive the turn-off they caused so the host can read why; power-up clears start/limit flags, start_i the inrush and cause bits
      sf_seen_q <= (sf_seen_q & ~turn_on) | sf_pulse;
      ilim_seen_q <= (ilim_seen_q & ~turn_on) | ilim_pulse;
      inrush_fault_o <= (inrush_fault_o & ~start_i_x2(start_i)) |
                        (sf_pulse & power_enable_change_flag_i);
      power_on_fault_cause_o <= (power_on_fault_cause_o & ~start_i_x2(start_i)) |
                                (sf_pulse & ~power_enable_change_flag_i & fault_cause_i);
    end
  end
  function [2*PORTS-1:0] start_i_x2;
    input [PORTS-1:0] s;
    integer i;
    begin
      for (i = 0; i < PORTS; i = i + 1)
      begin
        start_i_x2[2*i] = s[i];
        start_i_x2[2*i+1] = s[i];
      end
    end
  endfunction
  assign turn_on = channel_en_o & ~en_prev_q;
  assign start_fault_flag_o = sf_seen_q;
  assign current_limit_fault_flag_o = ilim_seen_q;
  assign clear_rd = rd_i && (rd_cmd_i == `PSEFE_CMD_SUPPLY_CLEAR);
  always @*
  begin
    events_d = events_q;
    if (clear_rd)
      events_d = 8'h00;
    // Set beats clear so a same-cycle event is kept
    events_d = events_d | rise;
  end
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      events_q <= `PSEFE_SUPPLY_RESET;
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
    end
    else
    begin
      events_q <= events_d;
      rd_valid_o <= rd_i;
      if (rd_i && (rd_cmd_i == `PSEFE_CMD_SUPPLY_VIEW || clear_rd))
        rd_data_o <= events_q;
      else if (rd_i)
        rd_data_o <= 8'h00;
    end
  end
  // Any set bit requests service; cleared by the clearing read
  assign supply_event_o = |events_q;
endmodule // psefe_supply_events

// ==== verification/psefe_supply_events_monitor.sv ====
module psefe_supply_events_monitor #(
  parameter PORTS = 4,
  parameter COOL_CYCLES = 50
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic rd_i,
  input wire logic [7:0] rd_cmd_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic thermal_hot_i,
  input wire logic [PORTS-1:0] start_i,
  input wire logic [PORTS-1:0] dual_sig_i,
  input wire logic [4*PORTS-1:0] class_i,
  input wire logic [PORTS-1:0] inrush_done_a_i,
  input wire logic [PORTS-1:0] start_fail_a_i,
  input wire logic [2*PORTS-1:0] channel_en_o,
  input wire logic [2*PORTS-1:0] power_good_flag_o,
  input wire logic [2*PORTS-1:0] start_fault_flag_o,
  input wire logic [PORTS-1:0] cooling_o,
  input wire logic supply_event_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // The synchroniser hides the temperature pin for a few cycles
  logic [1:0] cold_q;
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i) cold_q <= 2'h0;
    else if (thermal_hot_i) cold_q <= 2'h0;
    else if (cold_q != 2'h3) cold_q <= cold_q + 2'h1;
  sequence idle_go;
    start_i[0] && !dual_sig_i[0] && channel_en_o[1:0] == 2'h0 && !cooling_o[0] && cold_q == 2'h3;
  endsequence
  sequence first_done;
    !dual_sig_i[0] && channel_en_o[1:0] == 2'h1 && inrush_done_a_i[0] && cold_q == 2'h3;
  endsequence
  read_answer_a: assert property (rd_i |=> rd_valid_o) else $error("read not answered");
  no_stray_a: assert property (!rd_i |=> !rd_valid_o) else $error("stray read valid");
  flag_request_a: assert property (rd_valid_o && $past(rd_cmd_i) == 8'h0A && rd_data_o != 8'h00 |-> supply_event_o)
    else $error("set flag without request");
  hot_off_a: assert property (thermal_hot_i [*4] |=> channel_en_o == '0) else $error("hot but powered");
  low_one_a: assert property (idle_go ##0 class_i[3:0] <= 4'h6 |=> channel_en_o[1:0] == 2'h1)
    else $error("low class not one channel");
  high_both_a: assert property (idle_go ##0 class_i[3:0] >= 4'h7 |=> channel_en_o[1:0] == 2'h3)
    else $error("high class not both channels");
  second_on_a: assert property (first_done ##0 !start_fail_a_i[0] |=> channel_en_o[1:0] == 2'h3 &&
    power_good_flag_o[1:0] == 2'h3) else $error("second channel not on");
  fail_off_a: assert property (first_done ##0 start_fail_a_i[0] |=> channel_en_o[1:0] == 2'h0 &&
    start_fault_flag_o[1:0] == 2'h3 && cooling_o[0]) else $error("start fault not handled");
  cool_hold_a: assert property ($rose(cooling_o[0]) && !dual_sig_i[0] |->
    (channel_en_o[1:0] == 2'h0 && start_fault_flag_o[1:0] == 2'h3) [*8]) else $error("cool-down broken");
endmodule // psefe_supply_events_monitor
bind psefe_supply_events psefe_supply_events_monitor #(.PORTS(PORTS), .COOL_CYCLES(COOL_CYCLES)) mon_i (
  .clock_i(clock_i), .rst_i(rst_i), .rd_i(rd_i), .rd_cmd_i(rd_cmd_i), .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o), .thermal_hot_i(thermal_hot_i), .start_i(start_i), .dual_sig_i(dual_sig_i),
  .class_i(class_i), .inrush_done_a_i(inrush_done_a_i), .start_fail_a_i(start_fail_a_i),
  .channel_en_o(channel_en_o), .power_good_flag_o(power_good_flag_o),
  .start_fault_flag_o(start_fault_flag_o), .cooling_o(cooling_o), .supply_event_o(supply_event_o));

// ==== verification/psefe_host_model.sv ====
module psefe_host_model (
  input wire logic clock_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  output logic rd_o,
  output logic [7:0] cmd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    rd_o = 1'b0;
    cmd_o = 8'h00;
  end
  // One-byte read: strobe stands for the taking edge, answer is registered on that same edge and sampled just after it
  task automatic fetch(input logic [7:0] cmd, output logic [7:0] data, output logic ok);
    @(posedge clock_i);
    #1;
    rd_o = 1'b1;
    cmd_o = cmd;
    @(posedge clock_i);
    #1;
    rd_o = 1'b0;
    ok = rd_valid_i;
    data = rd_data_i;
  endtask
endmodule // psefe_host_model

// ==== verification/psefe_supply_events_test.sv ====
module test_psefe_supply_events;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int COOL = 50;
  logic clock_i = 1'b0, rst_i = 1'b1, start = 1'b0, dual = 1'b0, da = 1'b0, db = 1'b0, fa = 1'b0, fb = 1'b0;
  logic ila = 1'b0, ilb = 1'b0, rd, rv, sev, cool;
  logic [7:0] ev = 8'h00, cmd, rdat;
  logic [3:0] cls = 4'h0;
  logic [1:0] pec = 2'h0, power_on_command_bit = 2'h0, cause = 2'h0, en, pg, sf, lf, inf, pfc;
  int fails = 0, num_checks = 0;
  initial forever #2.5 clock_i = ~clock_i;
  psefe_supply_events #(.PORTS(1), .COOL_CYCLES(COOL)) psefe_supply_events_i (
    .clock_i(clock_i), .rst_i(rst_i), .rd_i(rd), .rd_cmd_i(cmd), .rd_data_o(rdat), .rd_valid_o(rv),
    .thermal_hot_i(ev[7]), .vdd_lockout_i(ev[6]), .vdd_warn_i(ev[5]), .main_uv_i(ev[4]),
    .cut_pair_b_i(ev[3]), .cut_pair_a_i(ev[2]), .fast_shutdown_input_i(ev[1]), .mem_fault_i(ev[0]),
    .start_i(start), .dual_sig_i(dual), .class_i(cls), .inrush_done_a_i(da), .inrush_done_b_i(db),
    .start_fail_a_i(fa), .start_fail_b_i(fb), .ilim_a_i(ila), .ilim_b_i(ilb),
    .power_enable_change_flag_i(pec), .power_on_command_bit_i(power_on_command_bit), .fault_cause_i(cause),
    .channel_en_o(en), .power_good_flag_o(pg), .start_fault_flag_o(sf), .current_limit_fault_flag_o(lf),
    .inrush_fault_o(inf), .power_on_fault_cause_o(pfc), .cooling_o(cool), .supply_event_o(sev));
  psefe_host_model psefe_host_model_i (.clock_i(clock_i), .rd_data_i(rdat), .rd_valid_i(rv), .rd_o(rd), .cmd_o(cmd));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
    check({6'h00, got}, {6'h00, exp});
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    psefe_host_model_i.fetch(c, d, ok);
    check({7'h00, ok}, 8'h01);
    check(d, exp);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic go(input logic d, input logic [3:0] c);
    dual = d;
    cls = c;
    start = 1'b1;
    step(1);
    start = 1'b0;
  endtask
  task automatic inr(input logic a, input logic b, input logic x, input logic y);
    {da, db, fa, fb} = {a, b, x, y};
    step(1);
    {da, db, fa, fb} = 4'h0;
    step(1);
  endtask
  // Heat forces the port off, then cooling lets it start again
  task automatic hot_off;
    ev[7] = 1'b1;
    step(5);
    chk2(en, 2'h0);
    ev[7] = 1'b0;
    step(4);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #200us;
    fails++;
    conclude;
  end
  initial
  begin
    step(5);
    rst_i = 1'b0;
    rd_chk(8'h0A, 8'h60);
    rd_chk(8'h0A, 8'h60);
    rd_chk(8'h0B, 8'h60);
    rd_chk(8'h0A, 8'h00);
    check({7'h00, sev}, 8'h00);
    rd_chk(8'h3C, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      ev[i] = 1'b1;
      step(5);
      ev[i] = 1'b0;
      check({7'h00, sev}, 8'h01);
      rd_chk(8'h0A, 8'h01 << i);
      rd_chk(8'h0B, 8'h01 << i);
      check({7'h00, sev}, 8'h00);
    end
    ev[0] = 1'b1;
    step(1);
    rd_chk(8'h0B, 8'h00);
    ev[0] = 1'b0;
    rd_chk(8'h0A, 8'h01);
    go(1'b0, 4'h6);
    chk2(en, 2'h1);
    inr(1'b1, 1'b0, 1'b1, 1'b0);
    chk2(en, 2'h0);
    chk2(sf, 2'h3);
    step(COOL + 5);
    go(1'b0, 4'h3);
    inr(1'b1, 1'b0, 1'b0, 1'b0);
    chk2(en, 2'h3);
    chk2(pg, 2'h3);
    hot_off;
    go(1'b0, 4'h8);
    chk2(en, 2'h3);
    inr(1'b1, 1'b1, 1'b0, 1'b1);
    chk2(en, 2'h0);
    chk2(sf, 2'h3);
    step(COOL + 5);
    go(1'b0, 4'h7);
    inr(1'b1, 1'b1, 1'b0, 1'b0);
    chk2(pg, 2'h3);
    chk2(en, 2'h3);
    hot_off;
    pec = 2'h2;
    go(1'b1, 4'h4);
    inr(1'b1, 1'b1, 1'b0, 1'b1);
    chk2(en, 2'h1);
    chk2(sf, 2'h2);
    chk2(inf, 2'h2);
    pec = 2'h0;
    cause = 2'h2;
    power_on_command_bit = 2'h2;
    for (int k = 0; k < COOL + 20 && en !== 2'h3; k++)
      step(1);
    power_on_command_bit = 2'h0;
    chk2(en, 2'h3);
    inr(1'b0, 1'b1, 1'b0, 1'b1);
    chk2(pfc, 2'h2);
    chk2(en, 2'h1);
    ila = 1'b1;
    step(1);
    ila = 1'b0;
    step(1);
    chk2(lf, 2'h1);
    conclude;
  end
endmodule // test_psefe_supply_events
